// ===== design/spdif_pkg.sv
// Shared constants and carrier types for the sub-frame transceiver.
// Assumes a single 50 MHz clock domain and synchronous pin inputs.
`default_nettype none
package spdif_pkg;
   localparam int CLK_PERIOD_NS = 20;
   // Silence on the input longer than this drops lock.
   localparam int LOSS_TIME_NS  = 2000;
   localparam int LOSS_CYCLES   = LOSS_TIME_NS / CLK_PERIOD_NS;
   localparam logic [7:0] LOSS_LEN = 8'(LOSS_CYCLES);
   localparam logic [7:0] UNIT_MAX = 8'hFF;
   // Half-cell length used for the free-running transmit clock.
   localparam logic [7:0] STD_UI   = 8'h08;
   localparam logic [3:0] PRE_UI   = 4'h8;
   localparam logic [5:0] DATA_UI  = 6'h08;
   localparam logic [5:0] LAST_UI  = 6'h3F;
   localparam logic [4:0] LAST_BIT = 5'h1B;
   localparam logic [7:0] LAST_FRM = 8'hBF;
   localparam logic [7:0] CONS_FRM = 8'h28;
   localparam int V_POS = 24;
   localparam int U_POS = 25;
   localparam int C_POS = 26;
   localparam int FIFO_DEPTH = 32;
   // Preamble levels, first half-cell in the top bit, for a low start.
   localparam logic [7:0] PRE_B = 8'hE8;
   localparam logic [7:0] PRE_M = 8'hE2;
   localparam logic [7:0] PRE_W = 8'hE4;
   typedef enum logic [1:0] {PRE_BLK, PRE_CHA, PRE_CHB} pre_t;
   typedef struct packed {
      logic        blk_start;
      logic        chan_b;
      logic        c;
      logic        u;
      logic        v;
      logic [23:0] sample;
   } sub_t;
   function automatic logic odd_par(input logic [27:0] w);
      return ^w;
   endfunction
endpackage
`default_nettype wire

// ===== design/spdif_subframe_transceiver.sv
// Sub-frame receiver, 32-word FIFO and sub-frame transmitter.
// Assumes spdif_rx_in and ext_tx_clk are already synchronous to mclk.
// How it works
// - Link is bi-phase-mark coded both ways.
// - Two sub-frames pair into one frame.
// - Preamble starts each sub-frame; one marks blocks.
// - Four auxiliary bits follow, LSB first.
// - Twenty audio bits, LSB first, make 24.
// - Validity bit set means sample invalid.
// - User bits collected into a block.
// - Channel-status bits form a status block.
// - Parity bit gives even parity, checked.
// - Only first 40 frames fill the blocks.
// - Transmitter never sends host user data.
// - Received user bits drive output pin 0.
// - Recovered audio goes out or loops through.
// - Recovered clock can drive the clock pin.
// - Without input, hold last or standard rate.
// - Transmit data from receiver or host input.
// - Transmit timing internal when looping, else external.
// - Handles 32k to 192k frames per second.
// - Reference clock between 10 and 27 MHz; this design runs on one 50 MHz mclk.
`default_nettype none

module sub_fifo #(
   parameter int WIDTH = 29,
   parameter int DEPTH = 32
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b0;
      end else begin
         wr_ptr <= wr_ptr + AW'(push);
         rd_ptr <= rd_ptr + AW'(pop);
         count <= next_count;
         in_ready <= (next_count != FULL);
      end
   end

   a_fifo_full_stall: assert property (@(posedge mclk) disable iff (!rst_n)
      (count == FULL) |-> !in_ready && !push)
      else $error("fifo accepted a word while full");
endmodule // sub_fifo

module spdif_subframe_transceiver (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        spdif_rx_in,
   output logic             spdif_tx_out,
   input  wire logic        src_sel,
   input  wire logic        hold_last_rate,
   input  wire logic        high_drive_clock_output_en,
   input  wire logic        ext_tx_clk,
   input  wire logic [39:0] tx_channel_status,
   input  wire spdif_pkg::sub_t sai_in,
   input  wire logic        sai_valid,
   output logic             sai_ready,
   output spdif_pkg::sub_t  rx_sub,
   output logic             rx_valid,
   output logic             parity_error,
   output logic             rx_error,
   output logic             locked,
   output logic [39:0]      cs_block,
   output logic [39:0]      user_block,
   output logic             block_done,
   output logic [2:0]       general_purpose_output_pin,
   output logic             high_drive_clock_output
);
   typedef enum {RX_HUNT, RX_PRE, RX_BITS} rx_state_t;
   rx_state_t          rx_state;
   spdif_pkg::pre_t    rx_kind;
   spdif_pkg::sub_t    f_in;
   spdif_pkg::sub_t    f_out;
   logic        rx_prev;
   logic [7:0]  rx_len;
   logic [7:0]  unit;
   logic [7:0]  last_unit;
   logic [3:0]  rx_uis;
   logic [3:0]  pre_sum;
   logic        rx_first;
   logic        rx_half;
   logic [4:0]  rx_bitn;
   logic [27:0] rx_shift;
   logic [27:0] word_next;
   logic [7:0]  frame_cnt;
   logic [7:0]  frame_idx;
   logic        edge_seen;
   logic        loss;
   logic [1:0]  cls;
   logic        bad;
   logic        bit_done;
   logic        bit_val;
   logic        sub_done;
   logic        f_valid;
   logic        f_out_valid;
   logic        f_pop;
   logic [7:0]  tx_div;
   logic [7:0]  tx_period;
   logic        div_tick;
   logic        ext_prev;
   logic        tx_tick;
   logic [5:0]  tx_ui;
   logic [4:0]  bidx;
   logic [27:0] tx_word;
   logic [7:0]  tx_pat;
   logic        tx_base;
   logic        tx_chb;
   logic [7:0]  tx_frame;
   logic [7:0]  new_frame;
   logic [26:0] tx_pay;
   logic        next_lvl;

   function automatic logic [1:0] ui_class(input logic [7:0] len, input logic [7:0] u);
      logic [10:0] l2;
      logic [10:0] uu;
      l2 = {2'h0, len, 1'b0};
      uu = {3'h0, u};
      if (l2 < 11'(uu * 11'h3)) return 2'h1;
      if (l2 < 11'(uu * 11'h5)) return 2'h2;
      return 2'h3;
   endfunction

   // Half-cells are measured against the shortest pulse seen; at 192k
   // frames a half-cell is about two clocks, so that end is marginal.
   assign edge_seen = spdif_rx_in ^ rx_prev;
   assign loss = (rx_len == spdif_pkg::LOSS_LEN);
   assign cls = ui_class(rx_len, unit);
   assign pre_sum = rx_uis + {2'h0, cls};
   assign sub_done = bit_done && (rx_bitn == spdif_pkg::LAST_BIT);
   assign word_next = {bit_val, rx_shift[27:1]};

   always_comb begin
      bit_done = 1'b0;
      bit_val = 1'b0;
      bad = 1'b0;
      if (rx_state == RX_BITS && edge_seen) begin
         if (cls == 2'h2) begin
            bit_done = ~rx_half;
            bad = rx_half;
         end else if (cls == 2'h1) begin
            bit_done = rx_half;
            bit_val = 1'b1;
         end else begin
            bad = 1'b1;
         end
      end
      if (rx_state == RX_PRE && edge_seen && pre_sum > spdif_pkg::PRE_UI) begin
         bad = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_prev <= 1'b0;
         rx_len <= 8'h01;
         unit <= spdif_pkg::UNIT_MAX;
      end else begin
         rx_prev <= spdif_rx_in;
         if (edge_seen) begin
            rx_len <= 8'h01;
         end else if (!loss) begin
            rx_len <= rx_len + 8'h01;
         end
         if (loss) begin
            unit <= spdif_pkg::UNIT_MAX;
         end else if (edge_seen && rx_len < unit) begin
            unit <= rx_len;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_state <= RX_HUNT;
         rx_kind <= spdif_pkg::PRE_BLK;
         rx_uis <= 4'h0;
         rx_first <= 1'b0;
         rx_half <= 1'b0;
         rx_bitn <= 5'h00;
         rx_shift <= 28'h0000000;
      end else if (loss || bad) begin
         rx_state <= RX_HUNT;
      end else begin
         case (rx_state)
            RX_HUNT: begin
               if (edge_seen && cls == 2'h3 && unit != spdif_pkg::UNIT_MAX) begin
                  rx_state <= RX_PRE;
                  rx_uis <= 4'h3;
                  rx_first <= 1'b1;
               end
            end
            RX_PRE: begin
               if (edge_seen) begin
                  rx_first <= 1'b0;
                  rx_uis <= pre_sum;
                  if (rx_first) begin
                     rx_kind <= (cls == 2'h1) ? spdif_pkg::PRE_BLK :
                                (cls == 2'h3) ? spdif_pkg::PRE_CHA : spdif_pkg::PRE_CHB;
                  end
                  if (pre_sum == spdif_pkg::PRE_UI) begin
                     rx_state <= RX_BITS;
                     rx_bitn <= 5'h00;
                     rx_half <= 1'b0;
                  end
               end
            end
            RX_BITS: begin
               if (edge_seen) begin
                  rx_half <= (cls == 2'h1) & ~rx_half;
               end
               if (bit_done) begin
                  rx_shift <= word_next;
                  rx_bitn <= rx_bitn + 5'h01;
               end
               if (sub_done) begin
                  rx_state <= RX_HUNT;
               end
            end
            default: rx_state <= RX_HUNT;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_sub <= '0;
         rx_valid <= 1'b0;
         parity_error <= 1'b0;
         rx_error <= 1'b0;
         locked <= 1'b0;
      end else begin
         rx_valid <= sub_done;
         rx_error <= bad | (loss & locked) | (sub_done & spdif_pkg::odd_par(word_next));
         if (loss || bad) begin
            locked <= 1'b0;
         end else if (sub_done) begin
            locked <= ~spdif_pkg::odd_par(word_next);
         end
         if (sub_done) begin
            parity_error <= spdif_pkg::odd_par(word_next);
            rx_sub <= '{blk_start: rx_kind == spdif_pkg::PRE_BLK,
                        chan_b: rx_kind == spdif_pkg::PRE_CHB,
                        c: word_next[spdif_pkg::C_POS],
                        u: word_next[spdif_pkg::U_POS],
                        v: word_next[spdif_pkg::V_POS],
                        sample: word_next[23:0]};
         end
      end
   end

   assign frame_idx = (rx_kind == spdif_pkg::PRE_BLK) ? 8'h00 :
                      (frame_cnt == spdif_pkg::LAST_FRM) ? frame_cnt : frame_cnt + 8'h01;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         frame_cnt <= 8'h00;
         cs_block <= 40'h0000000000;
         user_block <= 40'h0000000000;
         block_done <= 1'b0;
         general_purpose_output_pin <= 3'h0;
      end else begin
         block_done <= 1'b0;
         general_purpose_output_pin[2] <= parity_error | ~locked;
         if (sub_done && rx_kind != spdif_pkg::PRE_CHB) begin
            frame_cnt <= frame_idx;
            general_purpose_output_pin[1] <= (rx_kind == spdif_pkg::PRE_BLK);
            if (frame_idx < spdif_pkg::CONS_FRM) begin
               cs_block[frame_idx[5:0]] <= word_next[spdif_pkg::C_POS];
               user_block[frame_idx[5:0]] <= word_next[spdif_pkg::U_POS];
               block_done <= (frame_idx == spdif_pkg::CONS_FRM - 8'h01);
            end
         end
         if (sub_done) begin
            general_purpose_output_pin[0] <= word_next[spdif_pkg::U_POS];
         end
      end
   end

   assign f_in = src_sel ? sai_in : rx_sub;
   assign f_valid = src_sel ? sai_valid : rx_valid;

   sub_fifo #(.WIDTH($bits(spdif_pkg::sub_t)), .DEPTH(spdif_pkg::FIFO_DEPTH)) u_fifo (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .in_data   (f_in),
      .in_valid  (f_valid),
      .in_ready  (sai_ready),
      .out_data  (f_out),
      .out_valid (f_out_valid),
      .out_ready (f_pop)
   );

   assign tx_period = locked ? unit : (hold_last_rate ? last_unit : spdif_pkg::STD_UI);
   assign div_tick = (tx_div == 8'h00);
   assign tx_tick = src_sel ? (ext_tx_clk & ~ext_prev) : div_tick;
   assign f_pop = tx_tick && (tx_ui == spdif_pkg::LAST_UI);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_div <= 8'h00;
         last_unit <= spdif_pkg::STD_UI;
         ext_prev <= 1'b0;
         high_drive_clock_output <= 1'b0;
      end else begin
         ext_prev <= ext_tx_clk;
         tx_div <= div_tick ? tx_period - 8'h01 : tx_div - 8'h01;
         if (locked) begin
            last_unit <= unit;
         end
         if (!high_drive_clock_output_en) begin
            high_drive_clock_output <= 1'b0;
         end else if (div_tick) begin
            high_drive_clock_output <= ~high_drive_clock_output;
         end
      end
   end

   assign bidx = 5'((tx_ui - spdif_pkg::DATA_UI) >> 1);
   assign new_frame = !tx_chb ? tx_frame :
                      (tx_frame == spdif_pkg::LAST_FRM) ? 8'h00 : tx_frame + 8'h01;
   // empty FIFO sends an invalid sample
   assign tx_pay = {(new_frame < spdif_pkg::CONS_FRM) & tx_channel_status[new_frame[5:0]],
                    1'b0, f_out_valid ? f_out.v : 1'b1,
                    f_out_valid ? f_out.sample : 24'h000000};

   always_comb begin
      if (tx_ui < spdif_pkg::DATA_UI) begin
         next_lvl = tx_pat[3'h7 - tx_ui[2:0]] ^ tx_base;
      end else if (!tx_ui[0]) begin
         next_lvl = ~spdif_tx_out;
      end else begin
         next_lvl = spdif_tx_out ^ tx_word[bidx];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ui <= 6'h00;
         tx_word <= 28'h0000000;
         tx_pat <= spdif_pkg::PRE_B;
         tx_base <= 1'b0;
         tx_chb <= 1'b0;
         tx_frame <= 8'h00;
         spdif_tx_out <= 1'b0;
      end else if (tx_tick) begin
         spdif_tx_out <= next_lvl;
         tx_ui <= tx_ui + 6'h01;
         if (tx_ui == spdif_pkg::LAST_UI) begin
            tx_base <= next_lvl;
            tx_chb <= ~tx_chb;
            tx_frame <= new_frame;
            tx_pat <= tx_chb ? ((new_frame == 8'h00) ? spdif_pkg::PRE_B : spdif_pkg::PRE_M)
                             : spdif_pkg::PRE_W;
            tx_word <= {spdif_pkg::odd_par({1'b0, tx_pay}), tx_pay};
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_cell_start;
      tx_tick && tx_ui >= spdif_pkg::DATA_UI && !tx_ui[0];
   endsequence
   sequence s_blk_done;
      sub_done && rx_kind == spdif_pkg::PRE_BLK;
   endsequence

   a_tx_cell_edge: assert property (s_cell_start |=> spdif_tx_out != $past(spdif_tx_out))
      else $error("no level change at cell start");
   a_tx_user_zero: assert property (!tx_word[spdif_pkg::U_POS])
      else $error("user slot carries data");
   a_tx_even_par: assert property (!spdif_pkg::odd_par(tx_word))
      else $error("transmit word parity odd");
   a_rx_par_flag: assert property (rx_valid |-> parity_error == $past(spdif_pkg::odd_par(word_next)))
      else $error("parity flag wrong");
   a_blk_restart: assert property (s_blk_done |=> frame_cnt == 8'h00 && rx_sub.blk_start)
      else $error("block start not taken");
   a_cons_window: assert property (sub_done && frame_idx >= spdif_pkg::CONS_FRM |=> $stable(cs_block))
      else $error("status block changed outside window");
   a_high_drive_clock_output_off: assert property (!high_drive_clock_output_en |=> !high_drive_clock_output)
      else $error("clock pin runs while disabled");
   a_ext_timing: assert property (src_sel && !(ext_tx_clk && !ext_prev) |=> $stable(tx_ui))
      else $error("transmitter moved without external edge");
   a_loss_unlock: assert property (loss |=> !locked && rx_state == RX_HUNT)
      else $error("lock kept after silence");
endmodule // spdif_subframe_transceiver
`default_nettype wire

// ===== verification/spdif_link_model.sv
// Link partner: bi-phase-mark source on the receive pin, decoder on the transmit pin.
// Assumes the bench calls send and tail one time unit after a rising mclk edge.
`default_nettype none
module spdif_link_model #(
   parameter int HC = 4
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic tx_line,
   output logic      rx_line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        lvl = 1'h0;
   logic        last;
   logic        hf;
   logic [27:0] w;
   int          cnt, ph, sum, sec, nb;
   logic [29:0] got[$];
   // The line idles at its last level, so silence is what drops the lock.
   assign rx_line = lvl;
   task automatic half(input logic v);
      lvl = v;
      repeat (HC) @(posedge mclk);
      #1;
   endtask
   task automatic tail();
      half(~lvl);
   endtask
   task automatic send(input logic [7:0] pre, input logic [26:0] d, input logic bad);
      logic        s;
      logic [27:0] b;
      s = lvl;
      b = {(^d) ^ bad, d};
      for (int k = 7; k >= 0; k--) half(pre[k] ^ s);
      for (int i = 0; i < 28; i++) begin
         half(~lvl);
         half(lvl ^ b[i]);
      end
   endtask
   // Pulse widths back into tagged sub-frames.
   task automatic dec(input int r);
      case (ph)
         0: begin
            ph = (r == 3) ? 1 : 0;
            sum = 3;
            sec = 0;
         end
         1: begin
            if (sec == 0) sec = r;
            sum += r;
            ph = (sum == 8) ? 2 : (sum < 8) ? 1 : 0;
            nb = 0;
            hf = 1'h0;
         end
         default: begin
            if (r == 2 && !hf) begin
               w[nb] = 1'h0;
               nb++;
            end else if (r == 1) begin
               if (hf) begin
                  w[nb] = 1'h1;
                  nb++;
               end
               hf = ~hf;
            end else ph = 0;
            if (nb == 28) begin
               got.push_back({sec[1:0], w});
               ph = 0;
            end
         end
      endcase
   endtask
   always @(posedge mclk) begin
      if (!rst_n) begin
         last = 1'h0;
         cnt = 0;
         ph = 0;
      end else if (tx_line !== last) begin
         dec((cnt + HC / 2) / HC);
         cnt = 1;
         last = tx_line;
      end else cnt++;
   end
endmodule // spdif_link_model
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench: transceiver, link partner model and scenario tasks.
// Assumes the design package is compiled first and a single 50 MHz clock.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HC = 4;
   localparam logic [7:0] PB = spdif_pkg::PRE_B;
   localparam logic [7:0] PM = spdif_pkg::PRE_M;
   localparam logic [7:0] PW = spdif_pkg::PRE_W;
   logic            mclk, rst_n, rx_line, tx_line, src_sel, hold_last_rate;
   logic            high_drive_clock_output_en, ext_tx_clk, sai_valid, sai_ready, rx_valid;
   logic            parity_error, rx_error, locked, block_done, hdco, hdco_prev;
   logic [39:0]     tcs, cs_block, user_block, cs_cap, us_cap;
   logic [2:0]      gp_pin;
   spdif_pkg::sub_t sai_in, rx_sub;
   spdif_pkg::sub_t rxq[$];
   logic [1:0]      rxf[$];
   int              err_n, done_n, tog_n, cyc_n, bad_count, cmp_count;
   spdif_subframe_transceiver spdif_subframe_transceiver_i (
      .mclk(mclk), .rst_n(rst_n), .spdif_rx_in(rx_line), .spdif_tx_out(tx_line),
      .src_sel(src_sel), .hold_last_rate(hold_last_rate), .high_drive_clock_output_en(high_drive_clock_output_en),
      .ext_tx_clk(ext_tx_clk), .tx_channel_status(tcs), .sai_in(sai_in),
      .sai_valid(sai_valid), .sai_ready(sai_ready), .rx_sub(rx_sub), .rx_valid(rx_valid),
      .parity_error(parity_error), .rx_error(rx_error), .locked(locked),
      .cs_block(cs_block), .user_block(user_block), .block_done(block_done),
      .general_purpose_output_pin(gp_pin), .high_drive_clock_output(hdco));
   spdif_link_model #(.HC(HC)) link (
      .mclk(mclk), .rst_n(rst_n), .tx_line(tx_line), .rx_line(rx_line));
   task automatic complete_run();
      if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   function automatic logic [23:0] smp(input int k);
      return {8'hA5, 8'(k), 8'(~k)};
   endfunction
   initial begin
      mclk = 1'h0;
      forever #10 mclk = ~mclk;
   end
   // A run past the ceiling is a hang and ends as a mismatch.
   always @(posedge mclk) begin
      cyc_n++;
      if (rx_valid === 1'h1) begin
         rxq.push_back(rx_sub);
         rxf.push_back({gp_pin[0], parity_error});
      end
      if (rx_error === 1'h1) err_n++;
      if (block_done === 1'h1) begin
         done_n++;
         cs_cap = cs_block;
         us_cap = user_block;
      end
      if (hdco !== hdco_prev) tog_n++;
      hdco_prev = hdco;
      if (cyc_n == 80000) begin
         bad_count++;
         complete_run();
      end
   end
   task automatic tx_fifo();
      spdif_pkg::sub_t s;
      logic [29:0]     e;
      logic [26:0]     x;
      logic            p;
      int              f, k, hit;
      for (k = 0; k < 32; k++) begin
         s = {5'h07, smp(k)};
         s.v = k[0];
         sai_in = s;
         sai_valid = 1'h1;
         chk("sai_ready", 1, sai_ready);
         cyc(1);
      end
      sai_valid = 1'h0;
      cyc(1);
      chk("sai_ready full", 0, sai_ready);
      repeat (64 * 34 + 1) begin
         ext_tx_clk = 1'h1;
         cyc(HC / 2);
         ext_tx_clk = 1'h0;
         cyc(HC / 2);
      end
      chk("sai_ready drained", 1, sai_ready);
      f = 0;
      hit = -1;
      foreach (link.got[i]) begin
         e = link.got[i];
         if (e[29:28] == 2'h1) f = 0;
         else if (e[29:28] == 2'h3) f++;
         if (hit < 0 && e[23:0] === smp(0)) hit = i;
         if (hit >= 0 && i - hit < 32) begin
            k = i - hit;
            x = {(f < 40) ? tcs[f] : 1'h0, 1'h0, k[0], smp(k)};
            chk("tx sub-frame", {^x, x}, e[27:0]);
            if (k > 0) chk("tx channel order", p, e[29:28] != 2'h2);
            p = (e[29:28] == 2'h2);
         end
      end
      chk("tx word found", 1, hit >= 0);
      chk("tx empty word", 25'h1000000, link.got[$][24:0]);
   endtask
   task automatic rx_basic();
      spdif_pkg::sub_t a, b;
      int              n0;
      a = {5'h16, 24'h123456};
      b = {5'h09, 24'hF0E1D2};
      repeat (3) begin
         link.send(PB, a[26:0], 1'h0);
         link.send(PW, b[26:0], 1'h0);
      end
      link.tail();
      cyc(20);
      chk("rx channel A", a, rxq[rxq.size() - 2]);
      chk("rx channel B", b[27:0], rxq[$][27:0]);
      chk("user pin A", 2'h2, rxf[rxf.size() - 2]);
      chk("user pin B", 2'h0, rxf[$]);
      chk("locked", 1, locked);
      chk("block start pin", 1, gp_pin[1]);
      n0 = err_n;
      cyc(150);
      chk("lock lost", 0, locked);
      chk("loss error", 1, err_n > n0);
   endtask
   task automatic rx_parity();
      int n0;
      link.send(PB, 27'h0123456, 1'h0);
      link.send(PW, 27'h0654321, 1'h0);
      link.send(PM, 27'h1ABCDEF, 1'h0);
      n0 = err_n;
      link.send(PW, 27'h2345678, 1'h1);
      link.tail();
      cyc(20);
      chk("parity good", 0, rxf[rxf.size() - 2][0]);
      chk("parity bad", 1, rxf[$][0]);
      chk("parity level", 1, parity_error);
      chk("parity pulse", 1, err_n > n0);
      chk("error pin", 1, gp_pin[2]);
      cyc(150);
   endtask
   task automatic rx_block();
      logic [39:0] cs, us;
      logic        c, u;
      int          d0;
      cs = 40'h9A3C5AF00D;
      us = 40'h5CA3E10F72;
      d0 = done_n;
      link.send(PM, 27'h0, 1'h0);
      link.send(PW, 27'h0, 1'h0);
      for (int f = 0; f < 41; f++) begin
         c = (f < 40) ? cs[f] : ~cs[0];
         u = (f < 40) ? us[f] : ~us[0];
         link.send((f == 0) ? PB : PM, {c, u, 1'h0, 24'(f)}, 1'h0);
         link.send(PW, {~c, ~u, 1'h0, 24'(f)}, 1'h0);
      end
      link.tail();
      cyc(20);
      chk("block done count", 1, done_n - d0);
      chk("status block", cs, cs_cap);
      chk("user block", us, us_cap);
      chk("status after 40", cs, cs_block);
      cyc(150);
   endtask
   task automatic loop_through();
      logic hit;
      src_sel = 1'h0;
      hold_last_rate = 1'h1;
      repeat (4) begin
         link.send(PM, 27'h07E5A13, 1'h0);
         link.send(PW, 27'h0000000, 1'h0);
      end
      link.tail();
      cyc(3000);
      hit = 1'h0;
      foreach (link.got[i]) if (link.got[i][24:0] === 25'h07E5A13) hit = 1'h1;
      chk("looped word", 1, hit);
   endtask
   task automatic clk_pin();
      int t0;
      cyc(3);
      t0 = tog_n;
      cyc(40);
      chk("clock pin still", 0, tog_n - t0);
      chk("clock pin low", 0, hdco);
      high_drive_clock_output_en = 1'h1;
      t0 = tog_n;
      cyc(60);
      chk("clock pin runs", 1, tog_n - t0 > 4);
   endtask
   initial begin
      rst_n = 1'h0;
      src_sel = 1'h1;
      hold_last_rate = 1'h0;
      high_drive_clock_output_en = 1'h0;
      ext_tx_clk = 1'h0;
      tcs = 40'h000000A5C3;
      sai_in = '0;
      sai_valid = 1'h0;
      repeat (20) @(posedge mclk);
      #1;
      rst_n = 1'h1;
      cyc(2);
      tx_fifo();
      rx_basic();
      rx_parity();
      rx_block();
      loop_through();
      clk_pin();
      complete_run();
   end
endmodule // tb
`default_nettype wire
